// ==== common/cce_defs.svh ====
// register offsets, field positions and reset values of the channel checker
// assumes an 8-bit local register port, offsets are byte addresses
`ifndef CCE_DEFS_SVH
`define CCE_DEFS_SVH

`define CCE_CTRL_OFS     8'h46
`define CCE_STAT_OFS     8'h47
`define CCE_PSEL_OFS     8'h4c

`define CCE_CTRL_RST     8'h20
`define CCE_STAT_RST     8'h00
`define CCE_PSEL_RST     8'h00

`define CCE_EARLY_ACK    7
`define CCE_DATA_CHK     6
`define CCE_ENH_CHK      5
`define CCE_INJ_HI       4
`define CCE_INJ_LO       3
`define CCE_BYTE_HI      2
`define CCE_BYTE_LO      0

`define CCE_ST_SEQ       5
`define CCE_ST_CTL_ERR   4
`define CCE_ST_CTL_TO    3
`define CCE_ST_TGT_ERR   2
`define CCE_ST_TGT_TO    1
`define CCE_ST_RESP      0

`define CCE_PSEL_RD_HI   5
`define CCE_PSEL_RD_LO   4

`endif

// ==== common/cce_pkg.sv ====
// types shared by the channel checker files
// assumes nothing beyond the defs header
package cce_pkg;
	typedef logic [7:0] cce_byte_t;
	typedef logic [5:0] cce_evt_t;
	typedef enum logic [1:0] {
		CCE_INJ_NONE,
		CCE_INJ_CRC_SEL,
		CCE_INJ_CRC_NEXT,
		CCE_INJ_DATA
	} cce_inject_t;
endpackage

// ==== common/cce_bank_if.sv ====
// carrier between the checker top and one per-port register bank
// assumes the top drives strobes synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
interface cce_bank_if;
	logic                ctrl_wr;
	logic                stat_rd;
	cce_pkg::cce_byte_t  wdata;
	logic                mirror_seq;
	cce_pkg::cce_evt_t   evt;
	logic                inject_taken;
	cce_pkg::cce_byte_t  ctrl;
	cce_pkg::cce_byte_t  status;
	logic                inject_pend;
	modport bank (
		input  ctrl_wr, stat_rd, wdata, mirror_seq, evt, inject_taken,
		output ctrl, status, inject_pend
	);
	modport top (
		output ctrl_wr, stat_rd, wdata, mirror_seq, evt, inject_taken,
		input  ctrl, status, inject_pend
	);
endinterface
`default_nettype wire

// ==== hdl/cce_port_bank.sv ====
// one receive port's control register, sticky status and injection arm
// assumes strobes from the top are single-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "cce_defs.svh"
module cce_port_bank (
	input  wire logic    clk_sys,
	input  wire logic    rst,
	cce_bank_if.bank     bus
);
	cce_pkg::cce_byte_t  ctrl;
	cce_pkg::cce_byte_t  next_ctrl;
	cce_pkg::cce_evt_t   flags;
	cce_pkg::cce_evt_t   next_flags;
	cce_pkg::cce_evt_t   set_mask;
	logic                pend;
	logic                next_pend;
	logic                enh;

	assign enh = ctrl[`CCE_ENH_CHK];

	always_comb begin
		next_ctrl = ctrl;
		next_pend = pend;
		next_flags = flags;
		// only the target timeout is kept with enhanced checking off
		set_mask = bus.evt & {enh, enh, enh, enh, 1'b1, enh};
		if (bus.stat_rd) begin
			next_flags = '0;
		end
		next_flags = next_flags | set_mask;
		if (bus.ctrl_wr) begin
			next_ctrl = bus.wdata;
			next_pend = (bus.wdata[`CCE_INJ_HI:`CCE_INJ_LO] != 2'h0);
		end else if (bus.inject_taken) begin
			next_pend = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl <= `CCE_CTRL_RST;
			flags <= '0;
			pend <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			flags <= next_flags;
			pend <= next_pend;
		end
	end

	assign bus.ctrl = ctrl;
	assign bus.inject_pend = pend;
	// sequence bit mirrors the port status copy while enhanced checking is off
	assign bus.status = {2'h0, enh ? flags[`CCE_ST_SEQ] : bus.mirror_seq,
		flags[`CCE_ST_CTL_ERR:`CCE_ST_RESP]};

	sequence s_arm;
		bus.ctrl_wr && (bus.wdata[`CCE_INJ_HI:`CCE_INJ_LO] != 2'h0);
	endsequence
	sequence s_taken;
		pend && bus.inject_taken && !bus.ctrl_wr;
	endsequence

	a_ctrl_store: assert property (@(posedge clk_sys) disable iff (rst)
		bus.ctrl_wr |=> (ctrl == $past(bus.wdata)))
		else $error("control write not stored");
	a_inject_arm: assert property (@(posedge clk_sys) disable iff (rst)
		s_arm |=> pend)
		else $error("injection not armed");
	a_inject_once: assert property (@(posedge clk_sys) disable iff (rst)
		s_taken |=> !pend throughout (!bus.ctrl_wr)[*1])
		else $error("injection repeated after taken");
	a_seq_mirror: assert property (@(posedge clk_sys) disable iff (rst)
		!enh |-> (bus.status[`CCE_ST_SEQ] == bus.mirror_seq))
		else $error("sequence bit does not mirror");
	a_ctl_err: assert property (@(posedge clk_sys) disable iff (rst)
		enh && !bus.ctrl_wr && bus.evt[`CCE_ST_CTL_ERR]
		|=> bus.status[`CCE_ST_CTL_ERR])
		else $error("controller error flag missed");
	a_ctl_to: assert property (@(posedge clk_sys) disable iff (rst)
		!enh && !bus.ctrl_wr && !$past(bus.stat_rd) |=> 
		$stable(flags[`CCE_ST_CTL_TO]) || !flags[`CCE_ST_CTL_TO])
		else $error("controller timeout set while disabled");
	a_tgt_err: assert property (@(posedge clk_sys) disable iff (rst)
		enh && !bus.ctrl_wr && bus.evt[`CCE_ST_TGT_ERR]
		|=> bus.status[`CCE_ST_TGT_ERR])
		else $error("target error flag missed");
	a_tgt_to: assert property (@(posedge clk_sys) disable iff (rst)
		bus.evt[`CCE_ST_TGT_TO] |=> bus.status[`CCE_ST_TGT_TO])
		else $error("target timeout flag missed");
	a_read_clear: assert property (@(posedge clk_sys) disable iff (rst)
		bus.stat_rd && (bus.evt == '0) ##1 (bus.evt == '0)
		|-> (flags[`CCE_ST_CTL_ERR:`CCE_ST_RESP] == 5'h00))
		else $error("status not cleared by read");
	a_resp_flag: assert property (@(posedge clk_sys) disable iff (rst)
		enh && !bus.ctrl_wr && bus.stat_rd && bus.evt[`CCE_ST_RESP]
		|=> bus.status[`CCE_ST_RESP])
		else $error("response error lost on read");
endmodule
`default_nettype wire

// ==== hdl/cce_top.sv ====
// control channel error checking, injection and status for all rx ports
// assumes a synchronous local register port and link events as pulses
`timescale 1ns/100ps
`default_nettype none
`include "cce_defs.svh"
module cce_top #(
	parameter int NPORTS = 4
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	output logic                         reg_rvalid,
	input  wire logic [NPORTS-1:0]       port_status_seq,
	input  wire logic [NPORTS-1:0]       seq_err_evt,
	input  wire logic [NPORTS-1:0]       ctl_err_evt,
	input  wire logic [NPORTS-1:0]       ctl_to_evt,
	input  wire logic [NPORTS-1:0]       tgt_err_evt,
	input  wire logic [NPORTS-1:0]       tgt_to_evt,
	input  wire logic [NPORTS-1:0]       remote_read_start,
	output logic      [NPORTS-1:0]       early_ack,
	input  wire logic [NPORTS-1:0]       ack_cycle,
	input  wire logic [NPORTS-1:0]       remote_nack,
	input  wire logic [NPORTS-1:0][7:0]  ret_data,
	input  wire logic [NPORTS-1:0][7:0]  sent_data,
	output logic      [NPORTS-1:0]       local_nack,
	output logic      [NPORTS-1:0]       inject_req,
	output logic      [NPORTS-1:0][1:0]  inject_mode,
	output logic      [NPORTS-1:0][2:0]  inject_byte,
	input  wire logic [NPORTS-1:0]       inject_taken
);
	cce_pkg::cce_byte_t  psel;
	cce_pkg::cce_byte_t  next_psel;
	cce_pkg::cce_byte_t  next_rdata;
	logic                next_rvalid;
	logic [1:0]          rd_idx;
	logic                hit_ctrl;
	logic                hit_stat;
	logic                hit_psel;
	logic [NPORTS-1:0]   mismatch;
	cce_pkg::cce_byte_t  ctrl_all [NPORTS];
	cce_pkg::cce_byte_t  stat_all [NPORTS];

	cce_bank_if bank_if [NPORTS] ();

	assign hit_ctrl = (reg_addr == `CCE_CTRL_OFS);
	assign hit_stat = (reg_addr == `CCE_STAT_OFS);
	assign hit_psel = (reg_addr == `CCE_PSEL_OFS);
	assign rd_idx = psel[`CCE_PSEL_RD_HI:`CCE_PSEL_RD_LO];

	genvar g;
	generate
		for (g = 0; g < NPORTS; g++) begin : gen_port
			// writes may broadcast to several ports, reads reach one
			assign bank_if[g].ctrl_wr = reg_wr && hit_ctrl && psel[g];
			assign bank_if[g].stat_rd = reg_rd && hit_stat &&
				(rd_idx == 2'(g));
			assign bank_if[g].wdata = reg_wdata;
			assign bank_if[g].mirror_seq = port_status_seq[g];
			assign bank_if[g].inject_taken = inject_taken[g];
			assign mismatch[g] = ack_cycle[g] &&
				bank_if[g].ctrl[`CCE_DATA_CHK] &&
				(ret_data[g] != sent_data[g]);
			assign bank_if[g].evt = {seq_err_evt[g], ctl_err_evt[g],
				ctl_to_evt[g], tgt_err_evt[g], tgt_to_evt[g],
				mismatch[g]};
			assign ctrl_all[g] = bank_if[g].ctrl;
			assign stat_all[g] = bank_if[g].status;
			assign early_ack[g] = remote_read_start[g] &&
				bank_if[g].ctrl[`CCE_EARLY_ACK];
			assign local_nack[g] = remote_nack[g] || mismatch[g];
			assign inject_req[g] = bank_if[g].inject_pend;
			assign inject_mode[g] =
				bank_if[g].ctrl[`CCE_INJ_HI:`CCE_INJ_LO];
			assign inject_byte[g] =
				bank_if[g].ctrl[`CCE_BYTE_HI:`CCE_BYTE_LO];

			cce_port_bank u_bank (
				.clk_sys (clk_sys),
				.rst     (rst),
				.bus     (bank_if[g])
			);

			a_early_ack: assert property (@(posedge clk_sys) disable iff (rst)
				remote_read_start[g] |->
				(early_ack[g] == bank_if[g].ctrl[`CCE_EARLY_ACK]))
				else $error("early ack does not follow enable");
			a_data_check: assert property (@(posedge clk_sys) disable iff (rst)
				ack_cycle[g] && bank_if[g].ctrl[`CCE_DATA_CHK] &&
				bank_if[g].ctrl[`CCE_ENH_CHK] && !bank_if[g].ctrl_wr &&
				(ret_data[g] != sent_data[g])
				|=> bank_if[g].status[`CCE_ST_RESP])
				else $error("returned data error not flagged");
			a_nack_convert: assert property (@(posedge clk_sys) disable iff (rst)
				ack_cycle[g] && !remote_nack[g] &&
				bank_if[g].ctrl[`CCE_DATA_CHK]
				|-> (local_nack[g] == (ret_data[g] != sent_data[g])))
				else $error("mismatch not turned into nack");
			a_inject_byte: assert property (@(posedge clk_sys) disable iff (rst)
				bank_if[g].ctrl_wr |=>
				(inject_byte[g] == $past(reg_wdata[`CCE_BYTE_HI:`CCE_BYTE_LO])))
				else $error("injected byte select wrong");
		end
	endgenerate

	always_comb begin
		next_psel = psel;
		next_rvalid = reg_rd;
		next_rdata = 8'h00;
		if (reg_wr && hit_psel) begin
			next_psel = reg_wdata;
		end
		if (reg_rd) begin
			unique case (1'b1)
				hit_ctrl: next_rdata = (32'(rd_idx) < NPORTS) ?
					ctrl_all[rd_idx] : 8'h00;
				hit_stat: next_rdata = (32'(rd_idx) < NPORTS) ?
					stat_all[rd_idx] : 8'h00;
				hit_psel: next_rdata = psel;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			psel <= `CCE_PSEL_RST;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			psel <= next_psel;
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

	sequence s_stat_read;
		reg_rd && hit_stat && (32'(rd_idx) < NPORTS);
	endsequence

	a_port_read: assert property (@(posedge clk_sys) disable iff (rst)
		s_stat_read |=> reg_rvalid &&
		(reg_rdata == $past(stat_all[rd_idx])))
		else $error("status read from wrong port");
	a_enh_reset: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> ctrl_all[0][`CCE_ENH_CHK])
		else $error("enhanced checking not on after reset");
endmodule
`default_nettype wire

// ==== tb/cce_link_model.sv ====
// far-side link model: takes pending injections and echoes sent data
// assumes inputs from the bench settle at the falling edge of clk_sys
`timescale 1ns/100ps
`default_nettype none
module cce_link_model #(
	parameter int NPORTS = 4
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   slow,
	input  wire logic                   corrupt,
	input  wire logic [NPORTS-1:0]      inject_req,
	input  wire logic [NPORTS-1:0][7:0] sent_data,
	output logic      [NPORTS-1:0]      inject_taken,
	output logic      [NPORTS-1:0][7:0] ret_data
);
	logic [NPORTS-1:0][2:0] cnt;
	// echo returned data, port 0 flips a bit when asked
	always_comb begin
		ret_data = sent_data;
		if (corrupt)
			ret_data[0] = sent_data[0] ^ 8'h01;
	end
	// one take per pending injection, after 1 or 5 cycles
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			inject_taken <= '0;
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				inject_taken[p] <= 1'b0;
				cnt[p] <= (inject_req[p] && !inject_taken[p]) ? cnt[p] + 3'h1 : 3'h0;
				if (inject_req[p] && !inject_taken[p] && cnt[p] == (slow ? 3'h4 : 3'h0))
					inject_taken[p] <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/control_channel_error_check_tb.sv ====
// bench for the channel checker top: register calls with expected values
// assumes the defs header and package are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "cce_defs.svh"
module control_channel_error_check_tb;
	localparam int NP = 4;
	logic                clk_sys, rst, reg_wr, reg_rd, reg_rvalid;
	logic                slow, corrupt;
	logic [7:0]          reg_addr, reg_wdata, reg_rdata;
	logic [5:0]          ev;
	logic [NP-1:0]       port_status_seq, remote_read_start, early_ack;
	logic [NP-1:0]       remote_nack, local_nack, inject_req, inject_taken;
	logic [NP-1:0][7:0]  ret_data, sent_data;
	logic [NP-1:0][1:0]  inject_mode;
	logic [NP-1:0][2:0]  inject_byte;
	int                  failures, tests_run, i;

	cce_top #(.NPORTS(NP)) dut (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.port_status_seq(port_status_seq), .seq_err_evt({NP{ev[5]}}),
		.ctl_err_evt({NP{ev[4]}}), .ctl_to_evt({NP{ev[3]}}),
		.tgt_err_evt({NP{ev[2]}}), .tgt_to_evt({NP{ev[1]}}),
		.remote_read_start(remote_read_start), .early_ack(early_ack),
		.ack_cycle({NP{ev[0]}}), .remote_nack(remote_nack),
		.ret_data(ret_data), .sent_data(sent_data), .local_nack(local_nack),
		.inject_req(inject_req), .inject_mode(inject_mode),
		.inject_byte(inject_byte), .inject_taken(inject_taken));
	cce_link_model #(.NPORTS(NP)) link (.clk_sys(clk_sys), .rst(rst),
		.slow(slow), .corrupt(corrupt), .inject_req(inject_req),
		.sent_data(sent_data), .inject_taken(inject_taken),
		.ret_data(ret_data));

	always #4 clk_sys = ~clk_sys;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk({7'h0, reg_rvalid}, 8'h01);
		chk(reg_rdata, exp);
	endtask

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, slow, corrupt, reg_addr, reg_wdata, ev} = '0;
		{port_status_seq, remote_read_start, remote_nack} = '0;
		sent_data = {NP{8'ha5}};
		failures = 0;
		tests_run = 0;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		rd(`CCE_CTRL_OFS, `CCE_CTRL_RST);
		rd(`CCE_STAT_OFS, `CCE_STAT_RST);
		rd(8'h50, 8'h00);
		wr(`CCE_PSEL_OFS, 8'h01);
		wr(`CCE_CTRL_OFS, 8'h80);
		@(negedge clk_sys);
		remote_read_start = 4'hf;
		#1 chk({4'h0, early_ack}, 8'h01);
		@(negedge clk_sys);
		remote_read_start = 4'h0;
		wr(`CCE_CTRL_OFS, 8'h40);
		@(negedge clk_sys);
		ev[0] = 1'b1;
		corrupt = 1'b1;
		#1 chk({4'h0, local_nack}, 8'h01);
		@(negedge clk_sys);
		corrupt = 1'b0;
		remote_nack = 4'h2;
		#1 chk({4'h0, local_nack}, 8'h02);
		@(negedge clk_sys);
		remote_nack = 4'h0;
		ev = '0;
		for (int m = 0; m < 4; m++) begin
			slow = m[0];
			wr(`CCE_CTRL_OFS, {3'b001, m[1:0], 3'(2 * m + 1)});
			chk({6'h0, inject_mode[0]}, 8'(m));
			chk({5'h0, inject_byte[0]}, 8'(2 * m + 1));
			chk({7'h0, inject_req[0]}, {7'h0, m != 0});
			for (i = 0; i < 20 && inject_req[0]; i++)
				@(negedge clk_sys);
			if (inject_req[0] !== 1'b0) begin
				failures++;
				complete_run();
			end
			repeat (6) @(negedge clk_sys);
			chk({7'h0, inject_req[0]}, 8'h00);
		end
		wr(`CCE_PSEL_OFS, 8'h10);
		wr(`CCE_CTRL_OFS, 8'h00);
		rd(`CCE_CTRL_OFS, `CCE_CTRL_RST);
		wr(`CCE_PSEL_OFS, 8'h01);
		wr(`CCE_CTRL_OFS, 8'h60);
		corrupt = 1'b1;
		for (int k = 0; k < 6; k++) begin
			@(negedge clk_sys);
			ev[k] = 1'b1;
			@(negedge clk_sys);
			ev = '0;
			rd(`CCE_STAT_OFS, 8'h01 << k);
			rd(`CCE_STAT_OFS, 8'h00);
		end
		wr(`CCE_STAT_OFS, 8'hff);
		rd(`CCE_STAT_OFS, 8'h00);
		@(negedge clk_sys);
		reg_addr = `CCE_STAT_OFS;
		reg_rd = 1'b1;
		ev[4] = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		ev = '0;
		chk(reg_rdata, 8'h00);
		rd(`CCE_STAT_OFS, 8'h10);
		wr(`CCE_PSEL_OFS, 8'h12);
		// port 1 saw the broadcast events with enhanced checking on
		rd(`CCE_STAT_OFS, 8'h3e);
		wr(`CCE_CTRL_OFS, 8'h00);
		port_status_seq = 4'h2;
		@(negedge clk_sys);
		ev = 6'h3f;
		@(negedge clk_sys);
		ev = '0;
		rd(`CCE_STAT_OFS, 8'h22);
		rd(`CCE_STAT_OFS, 8'h20);
		port_status_seq = 4'h0;
		rd(`CCE_STAT_OFS, 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
